// ---- inc/rspc_pkg.sv ----
// Functional notes
// - Network reset restores only network settings, firmware and configuration kept.
// - Factory restore restores network settings, firmware image and configuration.
// - Restore switches are evaluated only during the boot following power-up.
// - Factory switch wins; network switch alone selects network reset; else normal.
// - During restore selection LEDs show a pattern naming the chosen option.
// - Restore starts only after both restore switches are seen off.
// - Restore pattern stays on the LEDs until the restore completes.
// - Switches not cleared within 30 s after boot abandon restore, boot normally.
// - Power cycle after abort with same switches re-enters restore selection.
// - Factory restore completion reboots the device without operator action.
// - After restore reboot use factory network address, green power LED on.
// - Live network-reset and factory-restore switch positions are readable.
// - Shutdown held 0.5 s disconnects stacks first, then removes own power.
// - Shutdown held continuously 10 s forces hardware power down.
// - Enable input restores power while the device is powered down.
// - With under-voltage lockout disabled, shutdown cannot remove power.
// - Firmware lockout configuration has no effect on shutdown behaviour.
// - Enable overrides shutdown and holds power on during lockout event.
// - Shutdown and enable input levels are readable while powered.
// - Under-voltage lockout is active only when its config switch is on.
package rspc_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned RESTORE_TIMEOUT_MS = 30_000;
  localparam int unsigned SOFT_SHDN_MS = 500;
  localparam int unsigned HARD_SHDN_MS = 10_000;
  localparam int unsigned DEBOUNCE_US = 1_000;
  localparam longint unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam longint unsigned RESTORE_TIMEOUT_CYC = RESTORE_TIMEOUT_MS * CYC_PER_MS;
  localparam longint unsigned SOFT_SHDN_CYC = SOFT_SHDN_MS * CYC_PER_MS;
  localparam longint unsigned HARD_SHDN_CYC = HARD_SHDN_MS * CYC_PER_MS;
  localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TMR_W = 33;
  // APB map, byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  // STATUS bit positions
  localparam int unsigned ST_NET_SW = 0;
  localparam int unsigned ST_FAC_SW = 1;
  localparam int unsigned ST_SHDN = 2;
  localparam int unsigned ST_EN = 3;
  localparam int unsigned ST_UVLO_SW = 4;
  localparam int unsigned ST_SEL_LO = 8;
  localparam int unsigned ST_PHASE_LO = 12;
  localparam int unsigned ST_DISC_REQ = 20;
  localparam int unsigned ST_PWR_ON = 21;
  localparam int unsigned ST_FACT_IP = 22;
  // Command bits: write one at CMD to report stacks disconnected / restore done; CTRL bit holds lockout event
  localparam int unsigned CT_DISC_DONE = 0;
  localparam int unsigned CT_RESTORE_DONE = 1;
  localparam int unsigned CT_UV_EVENT = 2;
  // LED codes: {green, amber, red}
  localparam logic [2:0] LED_OFF = 3'h0;
  localparam logic [2:0] LED_GREEN = 3'h4;
  localparam logic [2:0] LED_NET = 3'h2;
  localparam logic [2:0] LED_FAC = 3'h3;
  typedef enum logic [1:0] {SEL_NONE = 2'h0, SEL_NET = 2'h1, SEL_FAC = 2'h2} rspc_sel_type;
  typedef enum logic [5:0] {
    PH_BOOT = 6'h01, PH_WAIT_ACK = 6'h02, PH_RESTORE = 6'h04,
    PH_REBOOT = 6'h08, PH_RUN = 6'h10, PH_OFF = 6'h20
  } rspc_phase_type;
  // Restore actions to the storage controller
  typedef struct packed {
    logic reset_net;
    logic restore_fw;
    logic restore_cfg;
    logic reboot;
  } rspc_action_type;
endpackage : rspc_pkg

// ---- src/rspc_ctrl.sv ----
// Decided for this implementation: the APB interface to the registers and the address map.
module rspc_ctrl #(
  parameter longint unsigned RESTORE_TIMEOUT = rspc_pkg::RESTORE_TIMEOUT_CYC,
  parameter longint unsigned SOFT_SHDN = rspc_pkg::SOFT_SHDN_CYC,
  parameter longint unsigned HARD_SHDN = rspc_pkg::HARD_SHDN_CYC,
  parameter longint unsigned DEBOUNCE = rspc_pkg::DEBOUNCE_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic net_sw,
  input wire logic fac_sw,
  input wire logic uvlo_sw,
  input wire logic shdn_in,
  input wire logic en_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] led,
  output rspc_pkg::rspc_action_type action,
  output logic disc_req,
  output logic pwr_on,
  output logic fact_ip
);
  localparam logic [rspc_pkg::TMR_W-1:0] T_RESTORE = rspc_pkg::TMR_W'(RESTORE_TIMEOUT);
  localparam logic [rspc_pkg::TMR_W-1:0] T_SOFT = rspc_pkg::TMR_W'(SOFT_SHDN);
  localparam logic [rspc_pkg::TMR_W-1:0] T_HARD = rspc_pkg::TMR_W'(HARD_SHDN);
  localparam logic [rspc_pkg::TMR_W-1:0] T_DEB = rspc_pkg::TMR_W'(DEBOUNCE);

  // Saturating increment shared by all timers
  function automatic logic [rspc_pkg::TMR_W-1:0] tick(input logic [rspc_pkg::TMR_W-1:0] v);
    tick = (&v) ? v : v + 1'b1;
  endfunction : tick

  // Synchroniser pairs for five inputs: net, fac, uvlo, shdn, en
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] deb_reg;
  logic [4:0] raw;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end
    else
    begin
      sync1_reg <= {en_in, shdn_in, uvlo_sw, fac_sw, net_sw};
      sync2_reg <= sync1_reg;
    end
  end
  assign raw = sync2_reg;

  // Debounce: a level is accepted after it stays stable for the debounce time
  logic [rspc_pkg::TMR_W-1:0] deb_cnt_reg [5];
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      deb_reg <= 5'h00;
      for (int i = 0; i < 5; i++)
      begin
        deb_cnt_reg[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (raw[i] == deb_reg[i])
        begin
          deb_cnt_reg[i] <= '0;
        end
        else if (deb_cnt_reg[i] >= T_DEB - 1'b1)
        begin
          deb_reg[i] <= raw[i];
          deb_cnt_reg[i] <= '0;
        end
        else
        begin
          deb_cnt_reg[i] <= tick(deb_cnt_reg[i]);
        end
      end
    end
  end
  logic s_net, s_fac, s_uvlo, s_shdn, s_en;
  assign {s_en, s_shdn, s_uvlo, s_fac, s_net} = deb_reg;

  // APB-written control strobes
  logic disc_done, restore_done, uv_event_reg;
  logic wr;
  assign wr = psel && penable && pwrite;
  assign disc_done = wr && (paddr == rspc_pkg::ADDR_CMD) && pwdata[rspc_pkg::CT_DISC_DONE];
  assign restore_done = wr && (paddr == rspc_pkg::ADDR_CMD) && pwdata[rspc_pkg::CT_RESTORE_DONE];

  // Boot phase machine
  rspc_pkg::rspc_phase_type phase_reg;
  rspc_pkg::rspc_sel_type sel_reg;
  logic [rspc_pkg::TMR_W-1:0] boot_cnt_reg;
  logic [rspc_pkg::TMR_W-1:0] deb_wait_reg;
  logic fact_ip_reg;
  logic hard_off, soft_off, pwr_restore;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      phase_reg <= rspc_pkg::PH_BOOT;
      sel_reg <= rspc_pkg::SEL_NONE;
      boot_cnt_reg <= '0;
      deb_wait_reg <= '0;
      fact_ip_reg <= 1'b0;
    end
    else
    begin
      case (phase_reg)
        rspc_pkg::PH_BOOT:
        begin
          // Let the debouncers settle before sampling switches once
          deb_wait_reg <= tick(deb_wait_reg);
          if (deb_wait_reg >= T_DEB + 2'd3)
          begin
            if (s_fac)
            begin
              sel_reg <= rspc_pkg::SEL_FAC;
              phase_reg <= rspc_pkg::PH_WAIT_ACK;
            end
            else if (s_net)
            begin
              sel_reg <= rspc_pkg::SEL_NET;
              phase_reg <= rspc_pkg::PH_WAIT_ACK;
            end
            else
            begin
              sel_reg <= rspc_pkg::SEL_NONE;
              phase_reg <= rspc_pkg::PH_RUN;
            end
            boot_cnt_reg <= '0;
          end
        end
        rspc_pkg::PH_WAIT_ACK:
        begin
          boot_cnt_reg <= tick(boot_cnt_reg);
          if (!s_fac && !s_net)
          begin
            phase_reg <= rspc_pkg::PH_RESTORE;
          end
          else if (boot_cnt_reg >= T_RESTORE - 1'b1)
          begin
            sel_reg <= rspc_pkg::SEL_NONE;
            phase_reg <= rspc_pkg::PH_RUN;
          end
        end
        rspc_pkg::PH_RESTORE:
        begin
          if (restore_done)
          begin
            fact_ip_reg <= 1'b1;
            phase_reg <= (sel_reg == rspc_pkg::SEL_FAC) ? rspc_pkg::PH_REBOOT : rspc_pkg::PH_RUN;
          end
        end
        rspc_pkg::PH_REBOOT:
        begin
          phase_reg <= rspc_pkg::PH_RUN;
          sel_reg <= rspc_pkg::SEL_NONE;
        end
        rspc_pkg::PH_RUN:
        begin
          if (hard_off || soft_off)
          begin
            phase_reg <= rspc_pkg::PH_OFF;
          end
        end
        rspc_pkg::PH_OFF:
        begin
          if (pwr_restore)
          begin
            phase_reg <= rspc_pkg::PH_RUN;
          end
        end
        default:
        begin
          phase_reg <= rspc_pkg::PH_BOOT;
        end
      endcase
    end
  end

  // Shutdown timing; lockout switch gates power removal, firmware setting unused
  logic [rspc_pkg::TMR_W-1:0] shdn_cnt_reg;
  logic disc_pend_reg;
  logic may_off;
  assign may_off = s_uvlo && !s_en;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      shdn_cnt_reg <= '0;
    end
    else if (s_shdn && phase_reg == rspc_pkg::PH_RUN)
    begin
      shdn_cnt_reg <= tick(shdn_cnt_reg);
    end
    else
    begin
      shdn_cnt_reg <= '0;
    end
  end
  // Disconnect request held until firmware reports stacks open
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      disc_pend_reg <= 1'b0;
    end
    else if (phase_reg != rspc_pkg::PH_RUN)
    begin
      disc_pend_reg <= 1'b0;
    end
    else if (shdn_cnt_reg == T_SOFT - 1'b1 && may_off)
    begin
      disc_pend_reg <= 1'b1;
    end
    else if (disc_done)
    begin
      disc_pend_reg <= 1'b0;
    end
  end
  assign soft_off = disc_pend_reg && disc_done && may_off;
  assign hard_off = (shdn_cnt_reg >= T_HARD - 1'b1) && may_off;
  // Lockout event latch from firmware, cleared only by reset or a CTRL write with bit CT_UV_EVENT zero
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      uv_event_reg <= 1'b0;
    end
    else if (wr && paddr == rspc_pkg::ADDR_CTRL)
    begin
      uv_event_reg <= pwdata[rspc_pkg::CT_UV_EVENT];
    end
  end
  assign pwr_restore = s_en;

  // Outputs from flip-flops
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      led <= rspc_pkg::LED_OFF;
      action <= '0;
      disc_req <= 1'b0;
      pwr_on <= 1'b1;
      fact_ip <= 1'b0;
    end
    else
    begin
      if (phase_reg == rspc_pkg::PH_WAIT_ACK || phase_reg == rspc_pkg::PH_RESTORE)
      begin
        led <= (sel_reg == rspc_pkg::SEL_FAC) ? rspc_pkg::LED_FAC : rspc_pkg::LED_NET;
      end
      else if (phase_reg == rspc_pkg::PH_RUN)
      begin
        led <= rspc_pkg::LED_GREEN;
      end
      else
      begin
        led <= rspc_pkg::LED_OFF;
      end
      action.reset_net <= phase_reg == rspc_pkg::PH_RESTORE;
      action.restore_fw <= phase_reg == rspc_pkg::PH_RESTORE && sel_reg == rspc_pkg::SEL_FAC;
      action.restore_cfg <= phase_reg == rspc_pkg::PH_RESTORE && sel_reg == rspc_pkg::SEL_FAC;
      action.reboot <= phase_reg == rspc_pkg::PH_REBOOT;
      disc_req <= disc_pend_reg;
      pwr_on <= !(phase_reg == rspc_pkg::PH_OFF || hard_off || soft_off) || s_en;
      fact_ip <= fact_ip_reg;
    end
  end

  // APB slave: zero wait states, unmapped reads zero with error
  logic mapped;
  assign mapped = paddr == rspc_pkg::ADDR_STATUS || paddr == rspc_pkg::ADDR_CTRL || paddr == rspc_pkg::ADDR_CMD;
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite && paddr == rspc_pkg::ADDR_STATUS)
      begin
        prdata[rspc_pkg::ST_NET_SW] <= s_net;
        prdata[rspc_pkg::ST_FAC_SW] <= s_fac;
        prdata[rspc_pkg::ST_SHDN] <= s_shdn;
        prdata[rspc_pkg::ST_EN] <= s_en;
        prdata[rspc_pkg::ST_UVLO_SW] <= s_uvlo;
        prdata[rspc_pkg::ST_SEL_LO +: 2] <= sel_reg;
        prdata[rspc_pkg::ST_PHASE_LO +: 6] <= phase_reg;
        prdata[rspc_pkg::ST_DISC_REQ] <= disc_pend_reg;
        prdata[rspc_pkg::ST_PWR_ON] <= pwr_on;
        prdata[rspc_pkg::ST_FACT_IP] <= fact_ip_reg;
      end
      else if (psel && !penable && !pwrite && paddr == rspc_pkg::ADDR_CTRL)
      begin
        prdata[rspc_pkg::CT_UV_EVENT] <= uv_event_reg;
      end
    end
  end

  // Checks
  a_ack_starts_restore: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_WAIT_ACK && !s_fac && !s_net |=> phase_reg == rspc_pkg::PH_RESTORE)
    else $error("restore did not start on ack");
  a_fac_priority: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_BOOT && $changed(phase_reg) == 0 && s_fac && deb_wait_reg >= T_DEB + 2'd3
    |=> sel_reg == rspc_pkg::SEL_FAC)
    else $error("factory switch not prioritised");
  a_led_restore: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_RESTORE && sel_reg == rspc_pkg::SEL_FAC |=> led == rspc_pkg::LED_FAC)
    else $error("restore pattern missing");
  a_fac_reboot: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_RESTORE && restore_done && sel_reg == rspc_pkg::SEL_FAC
    |=> phase_reg == rspc_pkg::PH_REBOOT ##1 action.reboot)
    else $error("no reboot after factory restore");
  a_uvlo_blocks: assert property (@(posedge core_clk) disable iff (reset)
    !s_uvlo && phase_reg == rspc_pkg::PH_RUN |=> phase_reg == rspc_pkg::PH_RUN)
    else $error("power removed with lockout disabled");
  a_enable_holds: assert property (@(posedge core_clk) disable iff (reset)
    s_en |=> pwr_on)
    else $error("enable did not hold power");
  a_timeout_abort: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_WAIT_ACK && (s_fac || s_net) && boot_cnt_reg >= T_RESTORE - 1'b1
    |=> phase_reg == rspc_pkg::PH_RUN && sel_reg == rspc_pkg::SEL_NONE)
    else $error("restore not abandoned");
  a_soft_disc: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_RUN && shdn_cnt_reg == T_SOFT - 1'b1 && may_off |=> ##1 disc_req)
    else $error("no disconnect request");

  // Boot decode, restore pattern, power path and status checks
  a_net_select: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_BOOT && deb_wait_reg >= T_DEB + 2'd3 && !s_fac && s_net
    |=> sel_reg == rspc_pkg::SEL_NET && phase_reg == rspc_pkg::PH_WAIT_ACK)
    else $error("network switch not decoded");
  a_plain_boot: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_BOOT && deb_wait_reg >= T_DEB + 2'd3 && !s_fac && !s_net
    |=> sel_reg == rspc_pkg::SEL_NONE && phase_reg == rspc_pkg::PH_RUN)
    else $error("normal boot not taken");
  a_led_net: assert property (@(posedge core_clk) disable iff (reset)
    (phase_reg == rspc_pkg::PH_WAIT_ACK || phase_reg == rspc_pkg::PH_RESTORE) && sel_reg == rspc_pkg::SEL_NET
    |=> led == rspc_pkg::LED_NET)
    else $error("network pattern missing");
  a_net_only: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_RESTORE && sel_reg == rspc_pkg::SEL_NET
    |=> action.reset_net && !action.restore_fw && !action.restore_cfg)
    else $error("network reset touched firmware");
  a_hard_off: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_RUN && shdn_cnt_reg >= T_HARD - 1'b1 && may_off
    |=> phase_reg == rspc_pkg::PH_OFF && !pwr_on)
    else $error("hard shutdown missed");
  a_enable_wakes: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_OFF && s_en
    |=> phase_reg == rspc_pkg::PH_RUN)
    else $error("enable did not restore power");
  a_reboot_green: assert property (@(posedge core_clk) disable iff (reset)
    phase_reg == rspc_pkg::PH_REBOOT
    |=> phase_reg == rspc_pkg::PH_RUN && fact_ip_reg ##1 led == rspc_pkg::LED_GREEN)
    else $error("no green run after reboot");
  a_live_switches: assert property (@(posedge core_clk) disable iff (reset)
    psel && !penable && !pwrite && paddr == rspc_pkg::ADDR_STATUS
    |=> prdata[rspc_pkg::ST_NET_SW] == $past(s_net) && prdata[rspc_pkg::ST_FAC_SW] == $past(s_fac))
    else $error("switch status wrong");
  a_input_status: assert property (@(posedge core_clk) disable iff (reset)
    psel && !penable && !pwrite && paddr == rspc_pkg::ADDR_STATUS
    |=> prdata[rspc_pkg::ST_SHDN] == $past(s_shdn) && prdata[rspc_pkg::ST_EN] == $past(s_en))
    else $error("input status wrong");
endmodule : rspc_ctrl

// ---- tb/rspc_operator.sv ----
module rspc_operator (
  input wire logic core_clk,
  input wire logic [4:0] sw_cmd,
  output logic net_sw,
  output logic fac_sw,
  output logic uvlo_sw,
  output logic shdn_in,
  output logic en_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Operator moves the levels one edge after the command: {enable, shutdown, lockout, factory, network}
  always_ff @(posedge core_clk)
  begin
    {en_in, shdn_in, uvlo_sw, fac_sw, net_sw} <= sw_cmd;
  end
endmodule : rspc_operator

// ---- tb/tb_restore_shutdown_power_control.sv ----
module tb_restore_shutdown_power_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, reset, net_sw, fac_sw, uvlo_sw, shdn_in, en_in;
  logic psel, penable, pwrite, pready, pslverr, disc_req, pwr_on, fact_ip;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, st;
  logic [2:0] led;
  logic rerr, seen;
  logic [4:0] sw_cmd;
  rspc_pkg::rspc_action_type act;
  int bad_count = 0;
  int total_checks = 0;
  // Rows: {factory, network} at boot, then expected selection, LEDs, phase
  logic [12:0] rows [4] = '{{2'h0, 2'h0, 3'h4, 6'h10}, {2'h1, 2'h1, 3'h2, 6'h02},
                            {2'h2, 2'h2, 3'h3, 6'h02}, {2'h3, 2'h2, 3'h3, 6'h02}};

  rspc_ctrl #(.RESTORE_TIMEOUT(200), .SOFT_SHDN(20), .HARD_SHDN(60), .DEBOUNCE(4)) i_rspc_ctrl (
    .core_clk(core_clk), .reset(reset), .net_sw(net_sw), .fac_sw(fac_sw), .uvlo_sw(uvlo_sw),
    .shdn_in(shdn_in), .en_in(en_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .led(led), .action(act), .disc_req(disc_req), .pwr_on(pwr_on), .fact_ip(fact_ip));

  rspc_operator i_rspc_operator (.core_clk(core_clk), .sw_cmd(sw_cmd), .net_sw(net_sw), .fac_sw(fac_sw),
    .uvlo_sw(uvlo_sw), .shdn_in(shdn_in), .en_in(en_in));

  // 250 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      chk("pready", 32'h0, 32'h1);
  endtask : apb

  task automatic rs;
    apb(1'b0, rspc_pkg::ADDR_STATUS, 32'h0);
    st = rdat;
  endtask : rs

  // Operator command changes just after an edge
  task automatic set_sw(input logic [4:0] v);
    @(posedge core_clk);
    sw_cmd <= v;
  endtask : set_sw

  // Power cycle with the given switch levels set beforehand
  task automatic boot(input logic [4:0] v);
    set_sw(v);
    reset <= 1'b1;
    cyc(16);
    reset <= 1'b0;
    cyc(30);
  endtask : boot

  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Watchdog against a hung handshake or sequence
  initial
  begin
    cyc(20000);
    bad_count++;
    results();
  end

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sw_cmd = 5'h00;
    for (int i = 0; i < 4; i++)
    begin
      boot({3'h1, rows[i][12:11]});
      rs();
      chk("sel", 32'(st[9:8]), 32'(rows[i][10:9]));
      chk("led", 32'(led), 32'(rows[i][8:6]));
      chk("phase", 32'(st[17:12]), 32'(rows[i][5:0]));
      chk("live sw", 32'(st[1:0]), 32'(rows[i][12:11]));
    end
    $display("test boot decode done");
    // Network reset: acknowledged, runs until done
    boot(5'h05);
    set_sw(5'h04);
    cyc(30);
    rs();
    chk("phase", 32'(st[17:12]), 32'h4);
    chk("action", 32'(act), 32'h8);
    chk("led", 32'(led), 32'h2);
    apb(1'b1, rspc_pkg::ADDR_CMD, 32'h2);
    cyc(10);
    chk("fact ip", 32'(fact_ip), 32'h1);
    chk("led", 32'(led), 32'h4);
    $display("test network reset done");
    // Factory restore: pattern held past the timeout span, self reboot
    boot(5'h06);
    set_sw(5'h04);
    cyc(250);
    rs();
    chk("phase", 32'(st[17:12]), 32'h4);
    chk("action", 32'(act), 32'hE);
    chk("led", 32'(led), 32'h3);
    apb(1'b1, rspc_pkg::ADDR_CMD, 32'h2);
    seen = 1'b0;
    repeat (20)
    begin
      @(posedge core_clk);
      if (act.reboot === 1'b1)
        seen = 1'b1;
    end
    chk("reboot", 32'(seen), 32'h1);
    rs();
    chk("phase", 32'(st[17:12]), 32'h10);
    chk("fact ip", 32'({st[22], fact_ip}), 32'h3);
    chk("led", 32'(led), 32'h4);
    $display("test factory restore done");
    // Switches left on: abandoned, then power cycle re-enters selection
    boot(5'h06);
    cyc(220);
    rs();
    chk("phase", 32'(st[17:12]), 32'h10);
    chk("sel", 32'(st[9:8]), 32'h0);
    boot(5'h06);
    rs();
    chk("phase", 32'(st[17:12]), 32'h2);
    $display("test timeout done");
    // Interrupted shutdown restarts its count
    boot(5'h04);
    repeat (2)
    begin
      set_sw(5'h0C);
      cyc(12);
      set_sw(5'h04);
      cyc(12);
    end
    chk("disc", 32'(disc_req), 32'h0);
    // Soft shutdown: disconnect first, then power off; enable restores
    set_sw(5'h0C);
    cyc(40);
    chk("disc", 32'({disc_req, pwr_on}), 32'h3);
    apb(1'b1, rspc_pkg::ADDR_CMD, 32'h1);
    cyc(5);
    chk("pwr", 32'(pwr_on), 32'h0);
    set_sw(5'h1C);
    cyc(20);
    chk("pwr", 32'(pwr_on), 32'h1);
    rs();
    chk("shdn en", 32'(st[3:2]), 32'h3);
    // Hard shutdown with no disconnect report
    set_sw(5'h04);
    cyc(20);
    set_sw(5'h0C);
    cyc(100);
    chk("pwr", 32'(pwr_on), 32'h0);
    set_sw(5'h10);
    cyc(20);
    chk("pwr", 32'(pwr_on), 32'h1);
    $display("test shutdown done");
    // Lockout switch off, firmware lockout event, enable override
    boot(5'h00);
    set_sw(5'h08);
    apb(1'b1, rspc_pkg::ADDR_CTRL, 32'h4);
    apb(1'b0, rspc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", rdat, 32'h4);
    cyc(100);
    chk("pwr", 32'(pwr_on), 32'h1);
    rs();
    chk("uvlo sw", 32'(st[4]), 32'h0);
    set_sw(5'h1C);
    cyc(100);
    chk("pwr", 32'(pwr_on), 32'h1);
    apb(1'b0, 8'hFC, 32'h0);
    chk("slverr", {rdat[30:0], rerr}, 32'h1);
    $display("test override done");
    results();
  end
endmodule : tb_restore_shutdown_power_control
